/* File: cpmc_core.sv */
// clock and power-mode control with apb register access
`timescale 1ns/1ps
`include "cpmc_params.svh"
module cpmc_core (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic [31:0] config_word_in,
	input wire logic wait_exec_in,
	input wire logic irq_valid_in,
	input wire logic [2:0] irq_prio_in,
	input wire logic [2:0] cpu_prio_in,
	input wire logic wdt_timeout_in,
	input wire logic dev_reset_in,
	input wire logic osc_ready_in,
	input wire cpmc_pkg::cpmc_apb_req_t apb_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	output logic cpu_halt_out,
	output logic periph_clk_en_out,
	output logic stop_in_idle_bit_halt_out,
	output logic sys_clk_en_out,
	output logic clock_output_out,
	output logic [2:0] clk_src_out,
	output logic wdt_enable_out,
	output logic [4:0] wdt_postscale_out,
	output logic fail_safe_clock_monitor_enable_out,
	output logic sosc_enable_out
);
	import cpmc_pkg::*;

	cpmc_state_t s_q;
	cpmc_state_t s_d;
	logic wake_irq;
	logic wake_any;
	logic acc;
	logic [31:0] osc_rd;
	logic [4:0] ps;
	logic [2:0] div_mask;
	logic switch_allowed;
	logic need_delay;
	logic cfg_loaded_q;

	// ****************************************************************
	// decode and wake conditions
	// ****************************************************************
	// qualifying interrupt, synchronised pins
	assign wake_irq = s_q.w_sync1[0] && (irq_prio_in > cpu_prio_in);
	assign wake_any = s_q.w_sync1[1] || s_q.w_sync1[2];
	assign acc = apb_in.psel && apb_in.penable;
	assign ps = (s_q.cfg[`CPMC_CFG_WATCHDOG_POSTSCALE_LSB +: 5] > `CPMC_WATCHDOG_POSTSCALE_MAX) ?
		`CPMC_WATCHDOG_POSTSCALE_MAX : s_q.cfg[`CPMC_CFG_WATCHDOG_POSTSCALE_LSB +: 5];
	assign switch_allowed = !s_q.cfg[`CPMC_CFG_CKSM_LSB + 1];
	// crystal or pll source needs delay
	assign need_delay = (s_q.new_src == 3'h1) || (s_q.new_src == 3'h2) ||
		(s_q.new_src == 3'h3) || (s_q.new_src == 3'h4);
	assign div_mask = 3'((4'h1 << s_q.periph_bus_divisor_act) - 4'h1);
	always_comb begin
		osc_rd = 32'h0000_0000;
		osc_rd[`CPMC_PERIPH_BUS_DIVISOR_LSB +: 2] = s_q.periph_bus_divisor;
		osc_rd[`CPMC_SLEEP_EN_BIT] = s_q.sleep_en;
		osc_rd[`CPMC_NEW_SRC_LSB +: 3] = s_q.new_src;
		osc_rd[`CPMC_SWITCH_REQ_BIT] = (s_q.sw == CPMC_SW_WAIT);
		osc_rd[14:12] = s_q.cur_src;
	end

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		s_d = s_q;
		s_d.w_sync0 = {dev_reset_in, wdt_timeout_in, irq_valid_in};
		s_d.w_sync1 = s_q.w_sync0;
		s_d.rsp.pready = 1'b0;
		s_d.rsp.pslverr = 1'b0;
		// configuration word followed every cycle
		s_d.cfg = config_word_in;
		if (!cfg_loaded_q) begin
			s_d.periph_bus_divisor = config_word_in[`CPMC_CFG_PERIPH_BUS_DIVISOR_LSB +: 2];
			s_d.periph_bus_divisor_act = config_word_in[`CPMC_CFG_PERIPH_BUS_DIVISOR_LSB +: 2];
			s_d.cur_src = config_word_in[`CPMC_CFG_OSCILLATOR_SELECT_LSB +: 3];
			s_d.new_src = config_word_in[`CPMC_CFG_OSCILLATOR_SELECT_LSB +: 3];
		end
		s_d.pb_cnt = 3'(s_q.pb_cnt + 3'h1) & div_mask;
		s_d.pb_tick = (s_d.pb_cnt == 3'h0) && s_q.periph_run;
		if (s_d.pb_cnt == 3'h0 && cfg_loaded_q) begin
			s_d.periph_bus_divisor_act = s_q.periph_bus_divisor;
		end
		unique case (s_q.mode)
			CPMC_RUN: begin
				if (wait_exec_in) begin
					s_d.cpu_halt = 1'b1;
					if (s_q.sleep_en) begin
						s_d.mode = CPMC_SLEEP;
						s_d.periph_run = 1'b0;
					end else begin
						s_d.mode = CPMC_IDLE;
						s_d.stop_in_idle_bit_halt = 1'b1;
					end
				end
			end
			CPMC_IDLE: begin
				if (wake_irq || wake_any) begin
					s_d.mode = CPMC_RUN;
					s_d.cpu_halt = 1'b0;
					s_d.stop_in_idle_bit_halt = 1'b0;
				end
			end
			CPMC_SLEEP: begin
				if (wake_any || wake_irq) begin
					s_d.mode = CPMC_RUN;
					s_d.cpu_halt = 1'b0;
					s_d.periph_run = 1'b1;
				end else if (s_q.w_sync1[0]) begin
					s_d.mode = CPMC_IDLE;
					s_d.periph_run = 1'b1;
					s_d.stop_in_idle_bit_halt = 1'b1;
				end
			end
			default: begin
				s_d.mode = CPMC_RUN;
			end
		endcase
		// clock switch sequencer
		unique case (s_q.sw)
			CPMC_SW_IDLE: begin
				s_d.sw_cnt = 18'h0_0000;
			end
			CPMC_SW_WAIT: begin
				s_d.sw_cnt = 18'(s_q.sw_cnt + 18'h0_0001);
				if (!need_delay || (s_q.sw_cnt >=
					18'(`CPMC_OST_CYC + `CPMC_LOCK_CYC) && osc_ready_in)) begin
					s_d.cur_src = s_q.new_src;
					s_d.sw = CPMC_SW_IDLE;
				end
			end
			default: begin
				s_d.sw = CPMC_SW_IDLE;
			end
		endcase
		// apb slave, one wait state; status reads wait for the next peripheral clock tick
		if (acc && !s_q.rsp.pready) begin
			s_d.rsp.pready = 1'b1;
			s_d.rd_wait = 1'b0;
			unique case (apb_in.paddr)
				`CPMC_ADDR_OSC_CTRL: begin
					s_d.rsp.prdata = osc_rd;
					if (apb_in.pwrite) begin
						s_d.sleep_en = apb_in.pwdata[`CPMC_SLEEP_EN_BIT];
						s_d.periph_bus_divisor = apb_in.pwdata[`CPMC_PERIPH_BUS_DIVISOR_LSB +: 2];
						s_d.new_src = apb_in.pwdata[`CPMC_NEW_SRC_LSB +: 3];
						if (apb_in.pwdata[`CPMC_SWITCH_REQ_BIT] &&
							switch_allowed && s_q.sw == CPMC_SW_IDLE) begin
							s_d.sw = CPMC_SW_WAIT;
						end
					end
				end
				`CPMC_ADDR_CONFIG: begin
					s_d.rsp.prdata = s_q.cfg;
				end
				`CPMC_ADDR_STATUS: begin
					s_d.rsp.prdata = {26'h0, s_q.periph_bus_divisor_act, s_q.periph_run,
						s_q.cpu_halt, s_q.mode};
					if (!s_q.pb_tick) begin
						s_d.rsp.pready = 1'b0;
						s_d.rd_wait = 1'b1;
					end
				end
				`CPMC_ADDR_WDOG: begin
					s_d.rsp.prdata = {31'h0, s_q.wdt_sw_en};
					if (apb_in.pwrite) begin
						s_d.wdt_sw_en = apb_in.pwdata[0];
					end
				end
				default: begin
					s_d.rsp.prdata = 32'h0000_0000;
					s_d.rsp.pslverr = 1'b1;
				end
			endcase
		end
		// clock output only in ext or off mode
		s_d.clock_output = s_q.cfg[`CPMC_CFG_CLOCK_OUTPUT_EN] &&
			((s_q.cfg[`CPMC_CFG_POSC_LSB +: 2] == 2'b11) ||
			(s_q.cfg[`CPMC_CFG_POSC_LSB +: 2] == 2'b00)) && s_q.pb_tick;
	end

	// ****************************************************************
	// state register and reset load from configuration
	// ****************************************************************
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			s_q <= '0;
			s_q.periph_run <= 1'b1;
			s_q.cfg <= 32'hFFFF_FFFF;
		end else begin
			s_q <= s_d;
		end
	end
	// reset defaults taken once after release
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			cfg_loaded_q <= 1'b0;
		end else begin
			cfg_loaded_q <= 1'b1;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			prdata_out <= 32'h0000_0000;
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
			cpu_halt_out <= 1'b0;
			periph_clk_en_out <= 1'b0;
			stop_in_idle_bit_halt_out <= 1'b0;
			sys_clk_en_out <= 1'b0;
			clock_output_out <= 1'b0;
			clk_src_out <= 3'h0;
			wdt_enable_out <= 1'b0;
			wdt_postscale_out <= 5'h00;
			fail_safe_clock_monitor_enable_out <= 1'b0;
			sosc_enable_out <= 1'b0;
		end else begin
			prdata_out <= s_d.rsp.prdata;
			pready_out <= s_d.rsp.pready;
			pslverr_out <= s_d.rsp.pslverr;
			cpu_halt_out <= s_d.cpu_halt;
			// divided enable only for bus peripherals
			periph_clk_en_out <= s_d.pb_tick;
			stop_in_idle_bit_halt_out <= s_d.stop_in_idle_bit_halt;
			sys_clk_en_out <= (s_d.mode != CPMC_SLEEP);
			clock_output_out <= s_d.clock_output;
			clk_src_out <= s_d.cur_src;
			wdt_enable_out <= s_q.cfg[`CPMC_CFG_WDT_EN] || s_q.wdt_sw_en;
			wdt_postscale_out <= ps;
			fail_safe_clock_monitor_enable_out <= (s_q.cfg[`CPMC_CFG_CKSM_LSB +: 2] == 2'b00);
			sosc_enable_out <= s_q.cfg[`CPMC_CFG_SOSC];
		end
	end
endmodule // cpmc_core

/* File: cpmc_core_sva.sv */
// assertions on the ports of the clock and power-mode control block
`timescale 1ns/1ps
module cpmc_core_sva (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic [31:0] config_word_in,
	input wire logic irq_valid_in,
	input wire logic [2:0] irq_prio_in,
	input wire logic [2:0] cpu_prio_in,
	input wire logic wdt_timeout_in,
	input wire logic dev_reset_in,
	input wire logic cpu_halt_out,
	input wire logic stop_in_idle_bit_halt_out,
	input wire logic sys_clk_en_out,
	input wire logic clock_output_out,
	input wire logic wdt_enable_out,
	input wire logic [4:0] wdt_postscale_out,
	input wire logic fail_safe_clock_monitor_enable_out,
	input wire logic sosc_enable_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	// ****
	// decode and wake checks
	// ****
	// config word held long enough for registered decode
	sequence s_cfg;
		$stable(config_word_in)[*4];
	endsequence
	property p_wdt_on;
		s_cfg ##0 config_word_in[23] |-> wdt_enable_out;
	endproperty
	a_wdt_on: assert property (p_wdt_on) else $error("wdt on");
	property p_watchdog_postscale;
		s_cfg |-> wdt_postscale_out == ((config_word_in[20:16] > 5'h14) ?
			5'h14 : config_word_in[20:16]);
	endproperty
	a_watchdog_postscale: assert property (p_watchdog_postscale) else $error("postscale");
	property p_fail_safe_clock_monitor;
		s_cfg |-> fail_safe_clock_monitor_enable_out == (config_word_in[15:14] == 2'h0);
	endproperty
	a_fail_safe_clock_monitor: assert property (p_fail_safe_clock_monitor) else $error("monitor");
	property p_clock_output;
		s_cfg ##0 !config_word_in[10] |-> !clock_output_out;
	endproperty
	a_clock_output: assert property (p_clock_output) else $error("clock out");
	property p_sosc;
		s_cfg |-> sosc_enable_out == config_word_in[5];
	endproperty
	a_sosc: assert property (p_sosc) else $error("secondary");
	property p_wake_hi;
		cpu_halt_out && irq_valid_in && irq_prio_in > cpu_prio_in
			|-> ##[1:8] !cpu_halt_out;
	endproperty
	a_wake_hi: assert property (p_wake_hi) else $error("irq wake");
	property p_wake_rst;
		cpu_halt_out && (wdt_timeout_in || dev_reset_in)
			|-> ##[1:8] !cpu_halt_out;
	endproperty
	a_wake_rst: assert property (p_wake_rst) else $error("rst wake");
	property p_stop_in_idle_bit;
		stop_in_idle_bit_halt_out |-> cpu_halt_out && sys_clk_en_out;
	endproperty
	a_stop_in_idle_bit: assert property (p_stop_in_idle_bit) else $error("stop in idle");
	property p_sleep_lo;
		cpu_halt_out && !sys_clk_en_out && irq_valid_in && !wdt_timeout_in
			&& !dev_reset_in && irq_prio_in <= cpu_prio_in
			|-> ##[1:8] (cpu_halt_out && sys_clk_en_out);
	endproperty
	a_sleep_lo: assert property (p_sleep_lo) else $error("to idle");
	c_idle: cover property (cpu_halt_out && sys_clk_en_out);
	c_sleep: cover property (cpu_halt_out && !sys_clk_en_out);
	c_wake: cover property ($fell(cpu_halt_out));
endmodule // cpmc_core_sva
bind cpmc_core cpmc_core_sva cpmc_core_sva_inst (.clk_in, .reset_in,
	.config_word_in, .irq_valid_in, .irq_prio_in, .cpu_prio_in,
	.wdt_timeout_in, .dev_reset_in, .cpu_halt_out, .stop_in_idle_bit_halt_out,
	.sys_clk_en_out, .clock_output_out, .wdt_enable_out,
	.wdt_postscale_out, .fail_safe_clock_monitor_enable_out, .sosc_enable_out);

/* File: cpmc_core_tb.sv */
// self-checking bench for the clock and power-mode control block
`timescale 1ns/1ps
module cpmc_core_tb;
	import cpmc_pkg::*;
	logic clk_in = 1'b0, reset_in = 1'b1, er;
	logic wait_exec_in = 1'b0, irq_valid_in = 1'b0;
	logic wdt_timeout_in = 1'b0, dev_reset_in = 1'b0, osc_ready_in;
	logic [31:0] config_word_in = 32'hffff_ffff, prdata_out, rd;
	logic [2:0] irq_prio_in = 3'h0, cpu_prio_in = 3'h3, clk_src_out;
	logic [4:0] wdt_postscale_out;
	logic pready_out, pslverr_out, cpu_halt_out, periph_clk_en_out;
	logic stop_in_idle_bit_halt_out, sys_clk_en_out, clock_output_out;
	logic wdt_enable_out, fail_safe_clock_monitor_enable_out, sosc_enable_out;
	logic [6:0] tab [9] = '{7'h22, 7'h25, 7'h63, 7'h26, 7'h50, 7'h08,
		7'h64, 7'h48, 7'h10}; // {sleep, irq, wdt, reset, prio}
	cpmc_apb_req_t apb_in = '0;
	int n_mismatch = 0, n_checks = 0, cyc = 0, i, t, e;
	integer seed = 32'hb411_e44f;
	int model [4] = '{0, 0, 0, 0}; // register words
	cpmc_core cpmc_core_inst (.clk_in, .reset_in, .config_word_in,
		.wait_exec_in, .irq_valid_in, .irq_prio_in, .cpu_prio_in,
		.wdt_timeout_in, .dev_reset_in, .osc_ready_in, .apb_in, .prdata_out,
		.pready_out, .pslverr_out, .cpu_halt_out, .periph_clk_en_out,
		.stop_in_idle_bit_halt_out, .sys_clk_en_out, .clock_output_out, .clk_src_out,
		.wdt_enable_out, .wdt_postscale_out, .fail_safe_clock_monitor_enable_out,
		.sosc_enable_out);
	cpmc_osc_model cpmc_osc_model_inst (.clk_in, .reset_in,
		.osc_ready_out(osc_ready_in));
	// ****
	// shared tasks
	// ****
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		apb_in <= '{1'b1, 1'b0, wr, a, d};
		@(posedge clk_in);
		apb_in.penable <= 1'b1;
		do @(posedge clk_in); while (pready_out !== 1'b1);
		rd = prdata_out;
		er = pslverr_out;
		apb_in <= '0;
		if (wr) model[a[3:2]] = d;
		@(posedge clk_in);
	endtask
	task automatic tick();
		do @(posedge clk_in); while (periph_clk_en_out !== 1'b1);
	endtask
	// spacing of two bus clock pulses
	task automatic gap(input int div);
		tick();
		t = cyc;
		tick();
		check(cyc - t, div);
	endtask
	// enter a low-power mode if running, then apply one wake event
	task automatic ev(input logic [6:0] row);
		if (cpu_halt_out !== 1'b1) begin
			apb(1'b1, 12'h000, {27'h0, row[6], 4'h0});
			wait_exec_in <= 1'b1;
			@(posedge clk_in);
			wait_exec_in <= 1'b0;
			repeat (4) @(posedge clk_in);
			check(cpu_halt_out, 1);
			check(sys_clk_en_out, !row[6]);
		end
		{irq_valid_in, wdt_timeout_in, dev_reset_in} <= row[5:3];
		irq_prio_in <= row[2:0];
		@(posedge clk_in);
		{wdt_timeout_in, dev_reset_in} <= 2'h0;
		repeat (8) @(posedge clk_in);
		irq_valid_in <= 1'b0;
		e = row[5] && row[2:0] <= cpu_prio_in;
		check(cpu_halt_out, e);
		if (e) begin
			check(sys_clk_en_out, 1);
			apb(1'b0, 12'h008, 0);
			check(rd[1:0], CPMC_IDLE);
		end
	endtask
	always #5 clk_in = ~clk_in;
	// cycle ceiling against hangs
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			n_mismatch++;
			wrap_up();
		end
	end
	// ****
	// main sequence
	// ****
	initial begin
		repeat (20) @(posedge clk_in);
		reset_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		apb(1'b0, 12'h0f0, 0);
		check(er, 1);
		for (i = 0; i < 4; i++) begin
			apb(1'b1, 12'h000, i << 19);
			apb(1'b0, 12'h000, 0);
			check(rd[20:19], model[0] >> 19);
			repeat (16) @(posedge clk_in);
			gap(1 << i);
		end
		for (i = 0; i < 12; i++) begin
			config_word_in <= $random(seed) | 32'hff60_0858;
			apb(1'b1, 12'h00c, $random(seed) & 1);
			repeat (4) @(posedge clk_in);
			t = config_word_in[20:16];
			check(wdt_postscale_out, t > 20 ? 20 : t);
			check(fail_safe_clock_monitor_enable_out, config_word_in[15:14] == 2'h0);
			check(sosc_enable_out, config_word_in[5]);
			check(wdt_enable_out, config_word_in[23] | model[3][0]);
			if (!config_word_in[10]) check(clock_output_out, 0);
		end
		config_word_in <= config_word_in & 32'hffff_3ff8;
		reset_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		reset_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		check(clk_src_out, config_word_in[2:0]);
		gap(1 << config_word_in[13:12]);
		apb(1'b1, 12'h000, 32'h0000_0301);
		repeat (1000) @(posedge clk_in);
		check(clk_src_out, 0);
		do @(posedge clk_in); while (clk_src_out !== 3'h3);
		for (i = 0; i < 9; i++) ev(tab[i]);
		wrap_up();
	end
endmodule // cpmc_core_tb

/* File: cpmc_osc_model.sv */
// crystal source model: stable only after its start-up time
`timescale 1ns/1ps
module cpmc_osc_model #(parameter int STARTUP_CYC = 200) (
	input wire logic clk_in,
	input wire logic reset_in,
	output logic osc_ready_out
);
	int cnt_q;
	// ****
	// start-up count
	// ****
	// crystal start-up delay
	always_ff @(posedge clk_in) begin
		if (reset_in) cnt_q <= 0;
		else if (cnt_q < STARTUP_CYC) cnt_q <= cnt_q + 1;
	end
	assign osc_ready_out = (cnt_q == STARTUP_CYC);
endmodule // cpmc_osc_model

/* File: cpmc_params.svh */
// constants for the clock and power-mode control block
// ********************************************************************
// Summary of operation
// - in sleep, wake cpu only for enabled interrupt above cpu priority
// - sleep wake at or below cpu priority: restart bus clock, enter idle
// - any reset or watchdog time-out also ends sleep
// - idle halts cpu, system clock runs; stop-in-idle peripherals halt
// - wait with sleep-enable bit 4 clear enters idle
// - idle wakes only above cpu priority, else stays idle
// - any reset or watchdog time-out ends idle
// - switch to a stopped crystal or pll source waits start-up and lock
// - no start-up delay on idle exit
// - divisor bits 20:19 give bus ratio 1:1, 1:2, 1:4 or 1:8
// - system-clocked blocks ignore peripheral divisor changes
// - status read completes at next peripheral clock edge
// - config bit 23 forces watchdog on; clear lets software enable
// - postscale bits 20-16 select 2^n, undefined codes act as 10100
// - bits 15-14: 1x no switching, 01 switching, 00 switching plus monitor
// - config bits 13-12 give reset divisor 1, 2, 4 or 8
// - bit 10 drives clock output only in mode 11 or 00
// - bits 9-8 decode primary oscillator mode
// - config bit 7 two-speed start-up enable is defined but not used
// - config bit 5 enables secondary oscillator
// - bits 2-0 choose the reset clock source
// ********************************************************************
`ifndef CPMC_PARAMS_SVH
`define CPMC_PARAMS_SVH
`define CPMC_ADDR_OSC_CTRL 12'h000
`define CPMC_ADDR_CONFIG 12'h004
`define CPMC_ADDR_STATUS 12'h008
`define CPMC_ADDR_WDOG 12'h00C
`define CPMC_SLEEP_EN_BIT 4
`define CPMC_NEW_SRC_LSB 8
`define CPMC_SWITCH_REQ_BIT 0
`define CPMC_PERIPH_BUS_DIVISOR_LSB 19
`define CPMC_CFG_WDT_EN 23
`define CPMC_CFG_WATCHDOG_POSTSCALE_LSB 16
`define CPMC_CFG_CKSM_LSB 14
`define CPMC_CFG_PERIPH_BUS_DIVISOR_LSB 12
`define CPMC_CFG_CLOCK_OUTPUT_EN 10
`define CPMC_CFG_POSC_LSB 8
`define CPMC_CFG_TWO_SPEED_STARTUP_ENABLE 7
`define CPMC_CFG_SOSC 5
`define CPMC_CFG_OSCILLATOR_SELECT_LSB 0
`define CPMC_WATCHDOG_POSTSCALE_MAX 5'h14
`define CPMC_OST_NS 10240
`define CPMC_LOCK_NS 20000
`define CPMC_CLK_NS 10
`define CPMC_OST_CYC ((`CPMC_OST_NS + `CPMC_CLK_NS - 1) / `CPMC_CLK_NS)
`define CPMC_LOCK_CYC ((`CPMC_LOCK_NS + `CPMC_CLK_NS - 1) / `CPMC_CLK_NS)
`define CPMC_ERR_ADDR 32'hDEAD_0000
`endif

/* File: cpmc_pkg.sv */
// types for the clock and power-mode control block
package cpmc_pkg;
	typedef enum logic [1:0] {
		CPMC_RUN = 2'b00,
		CPMC_IDLE = 2'b01,
		CPMC_SLEEP = 2'b10
	} cpmc_mode_t;
	typedef enum logic [1:0] {
		CPMC_SW_IDLE = 2'b00,
		CPMC_SW_WAIT = 2'b01
	} cpmc_sw_t;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} cpmc_apb_req_t;
	typedef struct packed {
		logic prdata_v;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} cpmc_apb_rsp_t;
	typedef struct packed {
		cpmc_mode_t mode;
		cpmc_sw_t sw;
		logic [2:0] cur_src;
		logic [2:0] new_src;
		logic [17:0] sw_cnt;
		logic sleep_en;
		logic [1:0] periph_bus_divisor;
		logic [1:0] periph_bus_divisor_act;
		logic [2:0] pb_cnt;
		logic pb_tick;
		logic wdt_sw_en;
		logic [31:0] cfg;
		logic rd_wait;
		logic cpu_halt;
		logic periph_run;
		logic stop_in_idle_bit_halt;
		logic clock_output;
		logic [2:0] w_sync0;
		logic [2:0] w_sync1;
		cpmc_apb_rsp_t rsp;
	} cpmc_state_t;
endpackage : cpmc_pkg
